// >>> shared/rfrx_defs.svh
// Constants for the receiver configuration register bank
//
// Function
// - SOF enable plus SOF raises start interrupt
// - Sticky SOF seen flag, software clearable
// - Subcarrier enable plus subcarrier raises interrupt
// - Sticky subcarrier seen flag until cleared
// - Live read-only subcarrier present indicator
// - Partial bytes stored despite CRC when enabled
// - Continuous receive keeps receiver active
// - Continuous mode appends error copy byte
// - Error in first three bytes discards, resets FIFO
// - Collision counts as reception error
// - Frame under three bytes is disturbance
// - No receive-complete interrupt for discarded frames
// - Rate codes 4h..7h select 106..847 kBd
// - Unit zero: count times 16 carrier periods
// - Unit one: count times half bit period
// - Ignore input for window after transmit
// - Upper nibble sets decoder minimum level
// - Lower nibble sets phase detector minimum
// - Half-bit unit uses transmit bit stream rate
`ifndef RFRX_DEFS_SVH
`define RFRX_DEFS_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RFRX_ADDR_DETECT    8'h34
`define RFRX_ADDR_CTRL      8'h35
`define RFRX_ADDR_WAIT      8'h36
`define RFRX_ADDR_THRESH    8'h37
// ----------------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------------
`define RFRX_SOF_EN_BIT     5
`define RFRX_SOF_SEEN_BIT   4
`define RFRX_SUBCARRIER_IRQ_ENABLE_BIT    2
`define RFRX_SUBC_SEEN_BIT  1
`define RFRX_SUBC_NOW_BIT   0
`define RFRX_CTRL_MASK      8'hcf
`define RFRX_PART_BIT       7
`define RFRX_CONT_BIT       6
`define RFRX_EMD_BIT        3
`define RFRX_WAIT_UNIT_BIT  7
// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define RFRX_RST_DETECT     8'h00
`define RFRX_RST_CTRL       8'h04
`define RFRX_RST_WAIT       8'h00
`define RFRX_RST_THRESH     8'h00
`define RFRX_EMD_BYTES      2'd3
// 16 carrier periods at 13.56 MHz = 1180 ns; at 25 ns round up
`define RFRX_CARRIER16_NS   1180
`define RFRX_CLK_NS         25
`define RFRX_CARRIER16_CYC  ((`RFRX_CARRIER16_NS + `RFRX_CLK_NS - 1) / `RFRX_CLK_NS)
`endif

// >>> shared/rfrx_pkg.sv
// Types for the receiver configuration register bank
package rfrx_pkg;
  // Rate codes of the receive baud field
  typedef enum logic [2:0] {
    RFRX_RATE_106 = 3'h4,
    RFRX_RATE_212 = 3'h5,
    RFRX_RATE_424 = 3'h6,
    RFRX_RATE_847 = 3'h7
  } rfrx_rate_e;

  // Frame events from the demodulator
  typedef struct packed {
    logic sof;
    logic subc_detect;
    logic subcarrier_now;
    logic byte_done;
    logic partial_end;
    logic rx_error;
    logic collision;
    logic frame_end;
  } rfrx_ev_s;

  // Decisions returned to the receive datapath
  typedef struct packed {
    logic store_partial;
    logic keep_running;
    logic append_err;
    logic fifo_flush;
    logic rx_done_irq;
  } rfrx_act_s;

  // Receive sequencer states, Gray along idle-ignore-listen-frame
  typedef enum logic [1:0] {
    RFRX_IDLE   = 2'b00,
    RFRX_IGNORE = 2'b01,
    RFRX_LISTEN = 2'b11,
    RFRX_FRAME  = 2'b10
  } rfrx_st_e;
endpackage

// >>> logic/rfrx_regs.sv
// Receiver configuration registers with detection and disturbance logic
`timescale 1ns/1ps
`include "rfrx_defs.svh"
module rfrx_regs #(
  parameter int HALF_BIT_CYC_106 = 189
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  output logic [7:0]             reg_rdata,
  // Transmit side
  input  wire logic              tx_end,
  input  wire logic [1:0]        bit_stream_rate,
  // Receive events, same clock
  input  wire rfrx_pkg::rfrx_ev_s rx_ev,
  input  wire logic [7:0]        error_status,
  // Outputs to datapath
  output rfrx_pkg::rfrx_act_s    rx_act,
  output logic [7:0]             err_byte,
  output logic                   start_frame_interrupt,
  output logic                   rx_ignore,
  output logic [2:0]             rx_rate,
  output logic [3:0]             decoder_min_threshold,
  output logic [3:0]             phase_min_threshold
);

  // Elaboration guard: half bit must stay one cycle at 847 kBd and fit 16 bits
  if (HALF_BIT_CYC_106 < 8 || HALF_BIT_CYC_106 > 65535) begin : g_bad_half_bit
    $error("HALF_BIT_CYC_106 out of range");
  end

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  logic [7:0] detect_reg, detect_next;
  logic [7:0] ctrl_reg, wait_reg, thresh_reg;
  logic       wr_det, wr_ctl, wr_wait, wr_thr;

  // Address decode
  assign wr_det  = reg_wr && (reg_addr == `RFRX_ADDR_DETECT);
  assign wr_ctl  = reg_wr && (reg_addr == `RFRX_ADDR_CTRL);
  assign wr_wait = reg_wr && (reg_addr == `RFRX_ADDR_WAIT);
  assign wr_thr  = reg_wr && (reg_addr == `RFRX_ADDR_THRESH);

  logic sof_en, subcarrier_irq_enable, sof_seen, subc_seen;
  assign sof_en    = detect_reg[`RFRX_SOF_EN_BIT];
  assign subcarrier_irq_enable   = detect_reg[`RFRX_SUBCARRIER_IRQ_ENABLE_BIT];
  assign sof_seen  = detect_reg[`RFRX_SOF_SEEN_BIT];
  assign subc_seen = detect_reg[`RFRX_SUBC_SEEN_BIT];

  // Sticky flags: write zero clears, a detection in the same cycle wins
  logic sof_seen_n, subc_seen_n, sof_en_n, subcarrier_irq_enable_n;
  assign sof_en_n    = wr_det ? reg_wdata[`RFRX_SOF_EN_BIT] : sof_en;
  assign subcarrier_irq_enable_n   = wr_det ? reg_wdata[`RFRX_SUBCARRIER_IRQ_ENABLE_BIT] : subcarrier_irq_enable;
  assign sof_seen_n  = rx_ev.sof |
                       (sof_seen & ~(wr_det & ~reg_wdata[`RFRX_SOF_SEEN_BIT]));
  assign subc_seen_n = rx_ev.subc_detect |
                       (subc_seen & ~(wr_det & ~reg_wdata[`RFRX_SUBC_SEEN_BIT]));
  // Reserved bits held at zero
  assign detect_next = {2'b00, sof_en_n, sof_seen_n, 1'b0, subcarrier_irq_enable_n, subc_seen_n, 1'b0};

  // Register update
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      detect_reg <= `RFRX_RST_DETECT;
      ctrl_reg   <= `RFRX_RST_CTRL;
      wait_reg   <= `RFRX_RST_WAIT;
      thresh_reg <= `RFRX_RST_THRESH;
    end else begin
      detect_reg <= detect_next;
      if (wr_ctl) begin
        ctrl_reg <= reg_wdata & `RFRX_CTRL_MASK;
      end
      if (wr_wait) begin
        wait_reg <= reg_wdata;
      end
      if (wr_thr) begin
        thresh_reg <= reg_wdata;
      end
    end
  end

  // Read mux; live subcarrier bit comes straight from the detector
  logic [7:0] det_view;
  assign det_view  = detect_reg | {7'h00, rx_ev.subcarrier_now};
  assign reg_rdata = (reg_addr == `RFRX_ADDR_DETECT) ? det_view :
                     (reg_addr == `RFRX_ADDR_CTRL)   ? ctrl_reg :
                     (reg_addr == `RFRX_ADDR_WAIT)   ? wait_reg :
                     (reg_addr == `RFRX_ADDR_THRESH) ? thresh_reg : 8'h00;

  // --------------------------------------------------------------------------
  // Interrupt and static configuration
  // --------------------------------------------------------------------------
  logic irq_reg;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (sof_en & rx_ev.sof) | (subcarrier_irq_enable & rx_ev.subc_detect);
    end
  end
  assign start_frame_interrupt = irq_reg;
  // Static fields go straight out; reserved rate codes are passed unchecked
  assign rx_rate               = ctrl_reg[2:0];
  assign decoder_min_threshold = thresh_reg[7:4];
  assign phase_min_threshold   = thresh_reg[3:0];

  // Control bits read by the frame logic
  logic part_en, cont_en, emd_en;
  assign part_en = ctrl_reg[`RFRX_PART_BIT];
  assign cont_en = ctrl_reg[`RFRX_CONT_BIT];
  assign emd_en  = ctrl_reg[`RFRX_EMD_BIT];

  // --------------------------------------------------------------------------
  // Ignore window timing
  // --------------------------------------------------------------------------
  // Half bit period: 106 kBd base, shifted down for faster transmit rates
  logic [15:0] unit_cyc;
  logic [15:0] half_bit;
  assign half_bit = 16'(HALF_BIT_CYC_106) >> bit_stream_rate;
  assign unit_cyc = wait_reg[`RFRX_WAIT_UNIT_BIT] ? half_bit
                                                  : 16'(`RFRX_CARRIER16_CYC);

  // Sequencer state and window counters; tx_end restarts them from any state
  rfrx_pkg::rfrx_st_e st_reg, st_next;
  logic [15:0] unit_cnt_reg;
  logic [6:0]  win_cnt_reg;
  logic        unit_tick;
  assign unit_tick = (unit_cnt_reg >= unit_cyc - 16'd1);

  // Sequencer next state
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      rfrx_pkg::RFRX_IDLE: begin
        if (tx_end) begin
          st_next = (wait_reg[6:0] == 7'd0) ? rfrx_pkg::RFRX_LISTEN : rfrx_pkg::RFRX_IGNORE;
        end
      end
      rfrx_pkg::RFRX_IGNORE: begin
        if (unit_tick && win_cnt_reg == 7'd1) begin
          st_next = rfrx_pkg::RFRX_LISTEN;
        end
      end
      rfrx_pkg::RFRX_LISTEN: begin
        if (rx_ev.sof) begin
          st_next = rfrx_pkg::RFRX_FRAME;
        end
      end
      rfrx_pkg::RFRX_FRAME: begin
        if (rx_ev.frame_end) begin
          // Continuous mode stays armed for the next frame
          st_next = cont_en ? rfrx_pkg::RFRX_LISTEN : rfrx_pkg::RFRX_IDLE;
        end
      end
      default: st_next = rfrx_pkg::RFRX_IDLE;
    endcase
    if (tx_end && st_reg != rfrx_pkg::RFRX_IDLE) begin
      st_next = (wait_reg[6:0] == 7'd0) ? rfrx_pkg::RFRX_LISTEN : rfrx_pkg::RFRX_IGNORE;
    end
  end

  // Window counters
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg       <= rfrx_pkg::RFRX_IDLE;
      unit_cnt_reg <= 16'd0;
      win_cnt_reg  <= 7'd0;
    end else begin
      st_reg <= st_next;
      if (tx_end) begin
        unit_cnt_reg <= 16'd0;
        win_cnt_reg  <= wait_reg[6:0];
      end else if (st_reg == rfrx_pkg::RFRX_IGNORE) begin
        unit_cnt_reg <= unit_tick ? 16'd0 : unit_cnt_reg + 16'd1;
        if (unit_tick) begin
          win_cnt_reg <= win_cnt_reg - 7'd1;
        end
      end
    end
  end
  assign rx_ignore = (st_reg == rfrx_pkg::RFRX_IGNORE);

  // --------------------------------------------------------------------------
  // Disturbance suppression and frame end actions
  // --------------------------------------------------------------------------
  // Byte count saturates at three; only the first three bytes matter
  logic [1:0] byte_cnt_reg;
  logic       bad_reg;
  logic       early_err, short_end, in_frame;
  assign in_frame  = (st_reg == rfrx_pkg::RFRX_FRAME);
  assign early_err = emd_en && in_frame && (rx_ev.rx_error || rx_ev.collision)
                     && (byte_cnt_reg < `RFRX_EMD_BYTES);
  assign short_end = emd_en && in_frame && rx_ev.frame_end
                     && (byte_cnt_reg < `RFRX_EMD_BYTES);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      byte_cnt_reg <= 2'd0;
      bad_reg      <= 1'b0;
    end else if (rx_ev.sof || !in_frame) begin
      byte_cnt_reg <= 2'd0;
      bad_reg      <= 1'b0;
    end else begin
      if (rx_ev.byte_done && byte_cnt_reg != `RFRX_EMD_BYTES) begin
        byte_cnt_reg <= byte_cnt_reg + 2'd1;
      end
      if (early_err) begin
        bad_reg <= 1'b1;
      end
    end
  end

  // Registered action outputs
  rfrx_pkg::rfrx_act_s act_reg;
  logic [7:0]          err_reg;
  logic                discard;
  assign discard = early_err | short_end | bad_reg;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      act_reg <= '0;
      err_reg <= 8'h00;
    end else begin
      act_reg.store_partial <= part_en & rx_ev.partial_end;
      act_reg.keep_running  <= cont_en;
      act_reg.append_err    <= cont_en & in_frame & rx_ev.frame_end & ~discard;
      act_reg.fifo_flush    <= early_err | short_end;
      act_reg.rx_done_irq   <= in_frame & rx_ev.frame_end & ~discard;
      if (in_frame && rx_ev.frame_end) begin
        err_reg <= error_status;
      end
    end
  end
  assign rx_act   = act_reg;
  assign err_byte = err_reg;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  // Interrupt, flags and register contents
  sof_irq_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (sof_en && rx_ev.sof) |=> start_frame_interrupt) else $error("sof irq missing");
  subc_irq_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (subcarrier_irq_enable && rx_ev.subc_detect) |=> start_frame_interrupt) else $error("subc irq missing");
  irq_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
    start_frame_interrupt |-> $past(rx_ev.sof || rx_ev.subc_detect)) else $error("spurious irq");
  irq_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !((sof_en && rx_ev.sof) || (subcarrier_irq_enable && rx_ev.subc_detect)) |=> !start_frame_interrupt)
    else $error("irq without enabled cause");
  sof_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_ev.sof |=> detect_reg[`RFRX_SOF_SEEN_BIT]) else $error("sof flag not set");
  sof_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (sof_seen && !wr_det) |=> sof_seen) else $error("sof flag dropped");
  subc_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (subc_seen && !wr_det) |=> subc_seen) else $error("subc flag dropped");
  subc_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_ev.subc_detect |=> subc_seen) else $error("subc flag not set");
  subc_live_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_addr == `RFRX_ADDR_DETECT) |-> (reg_rdata[0] == rx_ev.subcarrier_now)) else $error("live bit wrong");
  resv_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (detect_reg[7:6] == 2'b00) && (detect_reg[3] == 1'b0) && (ctrl_reg[5:4] == 2'b00))
    else $error("reserved bit set");

  // --------------------------------------------------------------------------
  // Frame result and ignore window assertions
  // --------------------------------------------------------------------------
  // Each ties a registered action, error copy or sequencer state to the event one cycle earlier
  emd_flush_a: assert property (@(posedge mclk) disable iff (!rst_n)
    early_err |=> (rx_act.fifo_flush && !rx_act.rx_done_irq)) else $error("disturbance not flushed");
  short_flush_a: assert property (@(posedge mclk) disable iff (!rst_n)
    short_end |=> rx_act.fifo_flush) else $error("short frame not flushed");
  emd_noirq_a: assert property (@(posedge mclk) disable iff (!rst_n)
    short_end |=> !rx_act.rx_done_irq) else $error("irq on discarded frame");
  good_done_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (in_frame && rx_ev.frame_end && !discard) |=> rx_act.rx_done_irq) else $error("receive done missing");
  part_store_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (part_en && rx_ev.partial_end) |=> rx_act.store_partial) else $error("partial byte dropped");
  part_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!part_en && rx_ev.partial_end) |=> !rx_act.store_partial) else $error("partial byte stored");
  cont_stay_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (in_frame && rx_ev.frame_end && cont_en && !tx_end) |=> (st_reg == rfrx_pkg::RFRX_LISTEN))
    else $error("continuous receive ended");
  append_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (in_frame && rx_ev.frame_end && cont_en && !discard) |=> rx_act.append_err)
    else $error("error byte not appended");
  err_copy_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (in_frame && rx_ev.frame_end) |=> (err_byte == $past(error_status))) else $error("error copy wrong");
  ignore_win_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tx_end && wait_reg[6:0] != 7'd0) |=> rx_ignore) else $error("ignore window not opened");
  window_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rx_ignore && unit_tick && win_cnt_reg == 7'd1 && !tx_end) |=> !rx_ignore)
    else $error("ignore window overran");

  // Main scenarios reached
  subc_irq_c: cover property (@(posedge mclk) disable iff (!rst_n) subcarrier_irq_enable && rx_ev.subc_detect);
  frame_ok_c: cover property (@(posedge mclk) disable iff (!rst_n) rx_act.rx_done_irq);
  frame_emd_c: cover property (@(posedge mclk) disable iff (!rst_n) rx_act.fifo_flush);
  cont_err_c: cover property (@(posedge mclk) disable iff (!rst_n) rx_act.append_err);
  window_c: cover property (@(posedge mclk) disable iff (!rst_n) rx_ignore ##1 !rx_ignore);

endmodule

// >>> testbench/rfrx_card_model.sv
// Behavioural card answering over the field
`timescale 1ns/1ps
module rfrx_card_model (
  // Clock
  input  wire logic          mclk,
  // Frame events and error copy
  output rfrx_pkg::rfrx_ev_s rx_ev,
  output logic [7:0]         error_status
);
  // ---------------------------------------------------------------
  // Event sequencing
  // ---------------------------------------------------------------
  // Quiet field at start
  initial begin
    rx_ev = '0;
    error_status = 8'h5a;
  end

  // One event for one cycle; error copy inverted once it is not valid
  task automatic pulse(input int k, input logic [7:0] e);
    @(posedge mclk);
    #1;
    if (k >= 0) rx_ev[k] = 1'b1;
    error_status = e;
    @(posedge mclk);
    #1;
    if (k >= 0) rx_ev[k] = 1'b0;
    error_status = ~e;
  endtask

  // Subcarrier level with a detect pulse when it appears
  task automatic subc(input logic on);
    @(posedge mclk);
    #1;
    rx_ev.subcarrier_now = on;
    pulse(on ? 6 : -1, 8'h00);
  endtask

  // Frame: start, n data slots with slot bad (if any) carrying event kind instead of a byte, then end
  task automatic frame(input int n, bad, kind, input logic [7:0] err);
    pulse(7, ~err);
    for (int i = 0; i < n; i++) pulse(i == bad ? kind : 4, ~err);
    pulse(0, err);
  endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the receiver register bank
`timescale 1ns/1ps
module testbench;
  // ---------------------------------------------------------------
  // Signals, expectation queue and counters
  // ---------------------------------------------------------------
  logic                mclk = 1'b0;
  logic                rst_n = 1'b0;
  logic                reg_wr = 1'b0;
  logic                tx_end = 1'b0;
  logic [7:0]          reg_addr = 8'h00;
  logic [7:0]          reg_wdata = 8'h00;
  logic [1:0]          bit_stream_rate = 2'd1;
  logic [7:0]          reg_rdata, err_byte, error_status, r;
  rfrx_pkg::rfrx_ev_s  rx_ev;
  rfrx_pkg::rfrx_act_s rx_act;
  logic                sfi, rx_ignore;
  logic [2:0]          rx_rate;
  logic [3:0]          dec_th, ph_th;
  logic [12:0]         notes[$];
  int                  num_errors = 0;
  int                  samples_checked = 0;

  always #12.5 mclk = ~mclk;

  // Small half-bit count keeps the window short
  rfrx_regs #(.HALF_BIT_CYC_106(8)) rfrx_regs_i (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_end(tx_end),
    .bit_stream_rate(bit_stream_rate), .rx_ev(rx_ev), .error_status(error_status),
    .rx_act(rx_act), .err_byte(err_byte), .start_frame_interrupt(sfi),
    .rx_ignore(rx_ignore), .rx_rate(rx_rate), .decoder_min_threshold(dec_th),
    .phase_min_threshold(ph_th));
  rfrx_card_model rfrx_card_model_i (.mclk(mclk), .rx_ev(rx_ev), .error_status(error_status));

  task automatic check(input string what, input logic [12:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Flags: irq, done, flush, append, partial; then error copy
  function automatic void note(input logic [4:0] f, input logic [7:0] e);
    notes.push_back({f, e});
  endfunction

  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, exp);
    @(posedge mclk);
    #1;
    reg_addr = a;
    #4;
    check("reg_rdata", {5'h00, exp}, {5'h00, reg_rdata});
  endtask

  task automatic kick();
    @(posedge mclk);
    #1;
    tx_end = 1'b1;
    @(posedge mclk);
    #1;
    tx_end = 1'b0;
  endtask

  // Counts ignore cycles over a span longer than any window used
  task automatic window(input logic [7:0] cfg, input int exp);
    int n;
    n = 0;
    wr(8'h36, cfg);
    kick();
    // First sample falls one step after the edge that took tx_end
    repeat (200) begin
      if (rx_ignore === 1'b1) n++;
      @(posedge mclk);
      #1;
    end
    check("ignore_cycles", 13'(exp), 13'(n));
  endtask

  task automatic fr(input int n, bad, kind, input logic [7:0] e);
    kick();
    rfrx_card_model_i.frame(n, bad, kind, e);
  endtask

  // ---------------------------------------------------------------
  // Watcher: each result takes the oldest note
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    logic [12:0] seen;
    #2;
    seen = {sfi, rx_act.rx_done_irq, rx_act.fifo_flush, rx_act.append_err,
            rx_act.store_partial, rx_act.rx_done_irq ? err_byte : 8'h00};
    if (seen[12:8] !== 5'h00) begin
      if (notes.size() == 0) check("event", 13'h0000, seen);
      else check("event", notes.pop_front(), seen);
    end
  end

  // Watchdog reckoned well above the run length
  initial begin
    #(25 * 5000);
    num_errors++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h91c7));
    repeat (5) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    rd(8'h34, 8'h00);
    rd(8'h35, 8'h04);
    rd(8'h36, 8'h00);
    rd(8'h37, 8'h00);
    wr(8'h34, 8'hff);
    rd(8'h34, 8'h24);
    wr(8'h35, 8'hff);
    rd(8'h35, 8'hcf);
    wr(8'h40, 8'h55);
    rd(8'h40, 8'h00);
    for (int c = 4; c < 8; c++) begin
      wr(8'h35, 8'(c));
      check("rx_rate", 13'(c), {10'h000, rx_rate});
    end
    r = 8'($urandom());
    wr(8'h37, r); // level picked by software
    check("thresholds", {5'h00, r}, {5'h00, dec_th, ph_th});
    window(8'h03, 144);
    window(8'h83, 12);
    bit_stream_rate = 2'd3;
    window(8'h82, 2);
    wr(8'h36, 8'h00);
    // Start of frame with its enable set, plain receive
    wr(8'h35, 8'h04);
    wr(8'h34, 8'h20);
    note(5'h10, 8'h00);
    r = 8'($urandom());
    note(5'h08, r); // three bytes precede the end
    fr(3, -1, 0, r);
    rd(8'h34, 8'h30);
    wr(8'h34, 8'h20);
    rd(8'h34, 8'h20);
    // Subcarrier appears and goes away
    wr(8'h34, 8'h04);
    kick();
    note(5'h10, 8'h00);
    rfrx_card_model_i.subc(1'b1);
    rd(8'h34, 8'h07);
    rfrx_card_model_i.subc(1'b0);
    rd(8'h34, 8'h06);
    wr(8'h34, 8'h00);
    rd(8'h34, 8'h00);
    // Continuous receive with disturbance suppression
    wr(8'h35, 8'h4c);
    @(posedge mclk);
    #1;
    check("keep_running", 13'h0001, {12'h000, rx_act.keep_running});
    note(5'h04, 8'h00);
    fr(4, 1, 2, 8'h11);
    note(5'h04, 8'h00);
    fr(4, 0, 1, 8'h22);
    note(5'h04, 8'h00);
    fr(2, -1, 0, 8'h33);
    r = 8'($urandom());
    note(5'h0a, r);
    rfrx_card_model_i.frame(3, -1, 0, r);
    // Partial byte kept only while storage is on
    wr(8'h35, 8'h84);
    @(posedge mclk);
    #1;
    check("keep_running", 13'h0000, {12'h000, rx_act.keep_running});
    note(5'h01, 8'h00);
    rfrx_card_model_i.pulse(3, 8'h00);
    wr(8'h35, 8'h04);
    rfrx_card_model_i.pulse(3, 8'h00);
    repeat (4) @(posedge mclk);
    check("pending", 13'h0000, 13'(notes.size()));
    tally_and_finish();
  end
endmodule
